// ==== core/pegs_edge.sv ====
// Synchroniser and change detector for a group of level signals.
module pegs_edge #(
    parameter int W = 5,
    parameter bit SYNC = 1'b1
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] level,
    output logic [W-1:0] change
);

    logic [W-1:0] stab;
    logic [W-1:0] prev_q;
    logic [W-1:0] prev_d;
    localparam int PRIME_LEN = SYNC ? 3 : 1;
    logic [2:0] prime_q;
    logic [2:0] prime_d;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            if (SYNC) begin : g_sync
                logic meta_q;
                logic stab_q;
                always_ff @(posedge mclk or negedge arst_n) begin // RQ18
                    if (!arst_n) begin
                        meta_q <= 1'b0;
                        stab_q <= 1'b0;
                    end else begin
                        meta_q <= din[i];
                        stab_q <= meta_q;
                    end
                end
                assign stab[i] = stab_q;
            end else begin : g_direct
                assign stab[i] = din[i];
            end
        end
    endgenerate

    // History is primed only once the synchroniser holds real samples.
    always_comb begin
        prev_d = stab;
        prime_d = {prime_q[1:0], 1'b1};
        change = prime_q[PRIME_LEN-1] ? (stab ^ prev_q) : '0; // RQ18
        level = stab;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prev_q <= '0;
            prime_q <= '0;
        end else begin
            prev_q <= prev_d;
            prime_q <= prime_d;
        end
    end

endmodule

// ==== core/pegs_pwrwatch.sv ====
// Watches both sockets' supply requests for power and 12 V changes.
module pegs_pwrwatch (
    input wire logic mclk,
    input wire logic arst_n,
    input wire pegs_pkg::pegs_sock_t [1:0] sock,
    output logic pwr_chg,
    output logic vpp12_chg
);

    pegs_pkg::pegs_sock_t [1:0] prev_q;
    pegs_pkg::pegs_sock_t [1:0] prev_d;
    logic primed_q;
    logic primed_d;
    logic [1:0] any_chg;
    logic [1:0] hv_chg;

    genvar s;
    generate
        for (s = 0; s < 2; s++) begin : g_sock
            assign any_chg[s] = (sock[s] != prev_q[s]); // RQ12
            assign hv_chg[s] = (sock[s].vpp == pegs_pkg::VPP_CODE_12V) !=
                (prev_q[s].vpp == pegs_pkg::VPP_CODE_12V); // RQ13
        end
    endgenerate

    always_comb begin
        prev_d = sock;
        primed_d = 1'b1;
        pwr_chg = primed_q & (|any_chg);
        vpp12_chg = primed_q & (|hv_chg);
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prev_q <= '0;
            primed_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            primed_q <= primed_d;
        end
    end

endmodule

// ==== core/pegs_top.sv ====
// Power-management extension bytes and general event status register.
module pegs_top (
    input wire logic mclk,
    input wire logic arst_n,
    input wire pegs_pkg::pegs_cfg_t cfg,
    output logic cfg_ack,
    output logic [31:0] cfg_rdata,
    input wire logic [1:0] video_port_enable_bit,
    input wire pegs_pkg::pegs_sock_t [1:0] sock_pwr,
    input wire logic [pegs_pkg::NUM_INPUTS-1:0] multi_pins,
    input wire logic [15:0] event_enable,
    input wire logic event_pin_routed,
    input wire logic [1:0] power_state_field,
    output logic general_event_output_n,
    output logic sec_bus_clk_stop,
    output logic sec_bus_pwr_off,
    output logic [15:0] event_flags
);

    logic [1:0] video_chg;
    logic [pegs_pkg::NUM_INPUTS-1:0] pin_chg;
    logic pwr_chg;
    logic vpp12_chg;

    // Card control bits are internal and already synchronous.
    pegs_edge #(
        .W(2),
        .SYNC(1'b0)
    ) u_video (
        .mclk(mclk),
        .arst_n(arst_n),
        .din(video_port_enable_bit),
        .level(),
        .change(video_chg)
    );

    pegs_edge #(
        .W(pegs_pkg::NUM_INPUTS),
        .SYNC(1'b1)
    ) u_pins (
        .mclk(mclk),
        .arst_n(arst_n),
        .din(multi_pins),
        .level(),
        .change(pin_chg)
    );

    pegs_pwrwatch u_pwr (
        .mclk(mclk),
        .arst_n(arst_n),
        .sock(sock_pwr),
        .pwr_chg(pwr_chg),
        .vpp12_chg(vpp12_chg)
    );

    // Access decode.
    logic [5:0] idx;
    logic hit_ext;
    logic hit_sts;
    logic sts_wr;
    logic [15:0] clr_mask;

    always_comb begin
        idx = cfg.addr[7:2];
        hit_ext = cfg.valid && (idx == pegs_pkg::IDX_PM_EXT);
        hit_sts = cfg.valid && (idx == pegs_pkg::IDX_EVT_STS) &&
            !cfg.func; // RQ9
        sts_wr = hit_sts && cfg.write;
        clr_mask = '0;
        if (sts_wr) begin
            clr_mask[7:0] = cfg.be[0] ? cfg.wdata[7:0] : 8'h00; // RQ7
            clr_mask[15:8] = cfg.be[1] ? cfg.wdata[15:8] : 8'h00; // RQ7
        end
    end

    // Sticky event flags.
    logic [15:0] flags_q;
    logic [15:0] flags_d;
    logic [15:0] set_mask;

    always_comb begin
        set_mask = '0;
        set_mask[pegs_pkg::STS_VIDEO_A] = video_chg[0]; // RQ10
        set_mask[pegs_pkg::STS_VIDEO_B] = video_chg[1]; // RQ11
        set_mask[pegs_pkg::STS_POWER] = pwr_chg; // RQ12
        set_mask[pegs_pkg::STS_VPP12] = vpp12_chg; // RQ13
        set_mask[pegs_pkg::STS_INPUT_LSB +: pegs_pkg::NUM_INPUTS] =
            pin_chg; // RQ14
        // Enable bits play no part in setting a flag.
        flags_d = ((flags_q & ~clr_mask) | set_mask) &
            pegs_pkg::STS_MASK; // RQ8 RQ15 RQ19
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            flags_q <= pegs_pkg::STS_RESET; // RQ19
        end else begin
            flags_q <= flags_d;
        end
    end

    // Active-low event output, held while any enabled flag stands and the event pin is routed.
    logic gev_n_q;
    logic gev_n_d;

    always_comb begin
        gev_n_d = !(event_pin_routed &&
            (|(flags_q & event_enable & pegs_pkg::STS_MASK))); // RQ16 RQ17
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            gev_n_q <= 1'b1;
        end else begin
            gev_n_q <= gev_n_d;
        end
    end

    // Secondary bus action on entry to D3hot.
    logic clk_stop_q;
    logic clk_stop_d;
    logic pwr_off_q;
    logic pwr_off_d;
    logic policy_en;
    logic action_stop;
    logic in_d3hot;

    always_comb begin
        policy_en = pegs_pkg::POLICY_VALUE[pegs_pkg::POLICY_EN_BIT]; // RQ1
        action_stop =
            pegs_pkg::POLICY_VALUE[pegs_pkg::ACTION_SEL_BIT]; // RQ2
        in_d3hot = (power_state_field == pegs_pkg::PSTATE_D3HOT);
        clk_stop_d = policy_en && in_d3hot && action_stop; // RQ3 RQ4
        pwr_off_d = policy_en && in_d3hot && !action_stop; // RQ3 RQ4
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            clk_stop_q <= 1'b0;
            pwr_off_q <= 1'b0;
        end else begin
            clk_stop_q <= clk_stop_d;
            pwr_off_q <= pwr_off_d;
        end
    end

    // Read return and acknowledge, one cycle after the request.
    logic ack_q;
    logic ack_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    always_comb begin
        ack_d = cfg.valid;
        rdata_d = '0;
        if (cfg.valid && !cfg.write) begin
            if (hit_ext) begin
                rdata_d[31:24] = pegs_pkg::PM_DATA_VALUE; // RQ6
                rdata_d[23:16] = pegs_pkg::POLICY_VALUE; // RQ1 RQ2 RQ5
            end else if (hit_sts) begin
                rdata_d[15:0] = flags_q & pegs_pkg::STS_MASK; // RQ15
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ack_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    assign cfg_ack = ack_q;
    assign cfg_rdata = rdata_q;
    assign general_event_output_n = gev_n_q;
    assign sec_bus_clk_stop = clk_stop_q;
    assign sec_bus_pwr_off = pwr_off_q;
    assign event_flags = flags_q;

endmodule

// ==== inc/pegs_pkg.sv ====
// Constants, field layouts and carrier types of the event status block.
// How it works
// RQ1: Policy byte bit 7 reads one; read-only.
// RQ2: Policy byte bit 6 reads one: D3hot stops clock.
// RQ3: Action select only honoured while policy enabled.
// RQ4: Disabled policy: power state leaves bus alone.
// RQ5: Policy byte bits 5 to 0 read zero.
// RQ6: Data byte always reads zero, read-only.
// RQ7: Writing one clears a flag; zero keeps it.
// RQ8: Flags set regardless of event enable bits.
// RQ9: Software reaches status only through function 0.
// RQ10: Bit 15 sets on function 0 video change.
// RQ11: Bit 14 sets on function 1 video change.
// RQ12: Bit 11 sets on any socket power change.
// RQ13: Bit 8 sets on 12 V request change.
// RQ14: Bits 4..0 set on pin level changes.
// RQ15: Reserved status bits always read zero.
// RQ16: Event output holds until enabled flag cleared.
// RQ17: Event output needs a pin routed for it.
// RQ18: Pins synchronised, compared with previous sample.
// RQ19: Flags reset to zero; set beats clear.
package pegs_pkg;

    localparam logic [5:0] IDX_PM_EXT = 6'h29;
    localparam logic [5:0] IDX_EVT_STS = 6'h2a;
    localparam logic [7:0] OFS_POLICY = 8'ha6;
    localparam logic [7:0] OFS_PM_DATA = 8'ha7;
    localparam logic [7:0] OFS_EVT_STS = 8'ha8;

    localparam int POLICY_EN_BIT = 7;
    localparam int ACTION_SEL_BIT = 6;
    localparam logic [7:0] POLICY_VALUE = 8'hc0;
    localparam logic [7:0] PM_DATA_VALUE = 8'h00;

    localparam int STS_VIDEO_A = 15;
    localparam int STS_VIDEO_B = 14;
    localparam int STS_POWER = 11;
    localparam int STS_VPP12 = 8;
    localparam int STS_INPUT_LSB = 0;
    localparam int NUM_INPUTS = 5;
    localparam logic [15:0] STS_MASK = 16'hc91f;
    localparam logic [15:0] STS_RESET = 16'h0000;

    localparam logic [1:0] PSTATE_D3HOT = 2'h3;
    localparam int VCC_W = 2;
    localparam int VPP_W = 2;
    localparam logic [VPP_W-1:0] VPP_CODE_12V = 2'h2;

    typedef struct packed {
        logic valid;
        logic write;
        logic func;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } pegs_cfg_t;

    typedef struct packed {
        logic [VCC_W-1:0] vcc;
        logic [VPP_W-1:0] vpp;
    } pegs_sock_t;

endpackage

// ==== sim/pegs_top_asserts.sv ====
// Concurrent checks on the ports of the event status block.
module pegs_chk (
    input wire logic mclk,
    input wire logic arst_n,
    input wire pegs_pkg::pegs_cfg_t cfg,
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata,
    input wire logic [1:0] video_port_enable_bit,
    input wire pegs_pkg::pegs_sock_t [1:0] sock_pwr,
    input wire logic [4:0] multi_pins,
    input wire logic [15:0] event_enable,
    input wire logic event_pin_routed,
    input wire logic [1:0] power_state_field,
    input wire logic general_event_output_n,
    input wire logic sec_bus_clk_stop,
    input wire logic sec_bus_pwr_off,
    input wire logic [15:0] event_flags
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    AST_POLICY: assert property (
        cfg.valid && !cfg.write && cfg.addr[7:2] == 6'h29
        |=> cfg_rdata[23:16] == 8'hc0) else $error("policy byte wrong");
    AST_DATA: assert property (
        cfg.valid && !cfg.write && cfg.addr[7:2] == 6'h29
        |=> cfg_rdata[31:24] == 8'h00) else $error("data byte wrong");
    AST_FUNC1: assert property (
        cfg.valid && cfg.func && cfg.addr[7:2] == 6'h2a
        |=> cfg_rdata == 32'h0) else $error("function 1 status read");
    AST_RSVD: assert property (
        (event_flags & 16'h36e0) == 16'h0) else $error("reserved flag set");
    AST_VIDA: assert property (
        $changed(video_port_enable_bit[0]) |-> ##[1:2] event_flags[15])
        else $error("video a flag missing");
    AST_VIDB: assert property (
        $changed(video_port_enable_bit[1]) |-> ##[1:2] event_flags[14])
        else $error("video b flag missing");
    AST_PWR: assert property (
        sock_pwr != $past(sock_pwr) |-> ##[1:2] event_flags[11])
        else $error("power flag missing");
    AST_VPP12: assert property (
        ((sock_pwr[0].vpp == pegs_pkg::VPP_CODE_12V) !=
        ($past(sock_pwr[0].vpp) == pegs_pkg::VPP_CODE_12V)) ||
        ((sock_pwr[1].vpp == pegs_pkg::VPP_CODE_12V) !=
        ($past(sock_pwr[1].vpp) == pegs_pkg::VPP_CODE_12V))
        |-> ##[1:2] event_flags[8]) else $error("12 V flag missing");
    AST_PIN: assert property (
        $changed(multi_pins[0]) |-> ##[2:4] event_flags[0])
        else $error("pin flag missing");
    AST_GEV: assert property (
        ((event_flags & event_enable) != 16'h0 && event_pin_routed
        && !cfg.valid) [*2] |-> !general_event_output_n)
        else $error("event output not low");
    AST_ROUTE: assert property (
        !event_pin_routed [*2] |-> general_event_output_n)
        else $error("event output without route");
    AST_CLKSTOP: assert property (
        (power_state_field == 2'h3) [*2] |-> sec_bus_clk_stop)
        else $error("clock not stopped");
    AST_NOPWROFF: assert property (
        !sec_bus_pwr_off) else $error("power removed");
    COV_ACK: cover property (cfg_ack);
    COV_GEV: cover property (!general_event_output_n);
    COV_STOP: cover property (sec_bus_clk_stop);
endmodule

bind pegs_top pegs_chk chk (.*);

// ==== sim/tb_top.sv ====
// Self-checking bench for the event status block.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, arst_n, cfg_ack, event_pin_routed;
    logic general_event_output_n, sec_bus_clk_stop, sec_bus_pwr_off;
    pegs_pkg::pegs_cfg_t cfg;
    pegs_pkg::pegs_sock_t [1:0] sock_pwr;
    logic [31:0] cfg_rdata;
    logic [1:0] video_port_enable_bit, power_state_field;
    logic [4:0] multi_pins;
    logic [15:0] event_enable, event_flags;
    logic [31:0] exp_q[$];
    int fails, check_count;
    pegs_top dut (.*);
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task chk(string n, logic [31:0] s, logic [31:0] e);
        check_count++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s exp %h got %h", n, e, s);
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task cyc(int n);
        repeat (n) @(posedge mclk);
    endtask
    task req(logic w, logic f, logic [7:0] a, logic [3:0] b,
             logic [31:0] d, logic [31:0] e);
        @(posedge mclk);
        cfg <= '{1'b1, w, f, a, b, d};
        exp_q.push_back(e);
        @(posedge mclk);
        cfg.valid <= 1'b0;
    endtask
    always @(negedge mclk) begin
        if (cfg_ack === 1'b1) begin
            if (exp_q.size() == 0)
                chk("ack", 32'h1, 32'h0);
            else
                chk("rdata", cfg_rdata, exp_q.pop_front());
        end
    end
    initial begin
        #20000;
        fails++;
        end_sim;
    end
    initial begin
        void'($urandom(32'hbe0b));
        arst_n = 1'b0;
        cfg = '0;
        video_port_enable_bit = 2'h0;
        sock_pwr = '0;
        multi_pins = 5'($urandom);
        event_enable = 16'h0;
        event_pin_routed = 1'b0;
        power_state_field = 2'h0;
        cyc(5);
        arst_n <= 1'b1;
        @(negedge mclk);
        chk("flags", {16'h0, event_flags}, 32'h0);
        chk("gev", {31'h0, general_event_output_n}, 32'h1);
        cyc(4);
        @(negedge mclk);
        chk("flags", {16'h0, event_flags}, 32'h0);
        $display("test reset done");
        req(0, 0, 8'ha4, 4'hf, 0, 32'h00c00000);
        req(1, 0, 8'ha4, 4'hf, $urandom, 0);
        req(0, 1, 8'ha4, 4'hf, 0, 32'h00c00000);
        $display("test pm bytes done");
        cyc(2);
        video_port_enable_bit <= 2'h3;
        sock_pwr[0] <= '{2'h1, pegs_pkg::VPP_CODE_12V};
        multi_pins <= ~multi_pins;
        cyc(6);
        req(0, 0, 8'ha8, 4'hf, 0, 32'hc91f);
        req(1, 0, 8'ha8, 4'h3, 0, 0);
        req(0, 0, 8'ha8, 4'hf, 0, 32'hc91f);
        req(1, 0, 8'ha8, 4'h1, 32'hffff, 0);
        req(0, 0, 8'ha8, 4'hf, 0, 32'hc900);
        req(1, 1, 8'ha8, 4'h3, 32'hffff, 0);
        req(0, 1, 8'ha8, 4'hf, 0, 0);
        req(0, 0, 8'ha8, 4'hf, 0, 32'hc900);
        req(1, 0, 8'ha8, 4'h3, 32'hffff, 0);
        req(0, 0, 8'ha8, 4'hf, 0, 0);
        req(0, 0, 8'hb0, 4'hf, 0, 0);
        $display("test status done");
        event_enable <= 16'h0001;
        event_pin_routed <= 1'b1;
        multi_pins[0] <= ~multi_pins[0];
        cyc(6);
        @(negedge mclk);
        chk("gev", {31'h0, general_event_output_n}, 32'h0);
        @(posedge mclk);
        event_pin_routed <= 1'b0;
        cyc(3);
        @(negedge mclk);
        chk("gev", {31'h0, general_event_output_n}, 32'h1);
        @(posedge mclk);
        event_pin_routed <= 1'b1;
        req(1, 0, 8'ha8, 4'h1, 32'h1, 0);
        cyc(3);
        @(negedge mclk);
        chk("gev", {31'h0, general_event_output_n}, 32'h1);
        $display("test event output done");
        @(posedge mclk);
        power_state_field <= 2'h3;
        cyc(3);
        @(negedge mclk);
        chk("clk_stop", {31'h0, sec_bus_clk_stop}, 32'h1);
        chk("pwr_off", {31'h0, sec_bus_pwr_off}, 32'h0);
        @(posedge mclk);
        power_state_field <= 2'h0;
        cyc(3);
        @(negedge mclk);
        chk("clk_stop", {31'h0, sec_bus_clk_stop}, 32'h0);
        chk("pending", exp_q.size(), 32'h0);
        $display("test power state done");
        end_sim;
    end
endmodule
